// ---- psfs_supervisor.sv ----
`timescale 1ns/1ps
//Contract
// - Buck input overcurrent sets its warning in status 0 and sends report.
// - That warning clears itself once the overcurrent is gone.
// - Buck overcurrent only warns; buck stays on with shortened duty.
// - Buck output under 90% sets low warning and sends status 0.
// - Low warning clears only after output is back at 94%.
// - Buck output under 80% shuts down, sets lockout, sends status 0.
// - Buck lockout drives the limit/fault output low.
// - Supply above overvoltage stop level shuts the buck off.
// - Supply below buck input low stop level shuts the buck off.
// - Supply below buck input low stop sets lockout and sends status 0.
// - Supply below 4.0V disables the buck.
// - Feedback pin held by external 2.5-5.5V forces buck shutdown.
// - Supply below pump start level enables the charge pump.
// - Config-lost flag set at power-up and when supply drops below 3.8V.
// - Supply under 5.5V or over 20V switches motor drivers off only; here it also drives the limit/fault output low.
// - Supply under/overvoltage state is reported over the serial link.
// - Supply above 32V turns off all functions.
// - Overtemperature turns off all functions.
// - Resume after overtemperature needs cool-down plus chip enable toggle.
// - Thermal warning sends a warning message over the serial link.
// - Messages are 9600 baud 8N1 half-duplex on the open-drain pin.
module psfs_supervisor
  import psfs_pkg::*;
#(
  parameter int unsigned BIT_CNT = BIT_CYCLES
) (
  input  wire logic               CLK_SYS,
  input  wire logic               ARST_N,
  input  wire logic               CLK_EN,
  input  wire logic [SENSE_W-1:0] SENSE,
  input  wire logic               SERIAL_LINK_PIN_IN,
  output logic                    SERIAL_LINK_PIN_OE_N,
  output logic                    SERIAL_LINK_PIN_OUT,
  output logic                    LIMIT_FAULT_OUTPUT,
  output logic                    BUCK_ENABLE,
  output logic                    BUCK_DUTY_LIMIT,
  output logic                    PUMP_ENABLE,
  output logic                    MOTOR_DRIVER_ENABLE,
  output logic                    ALL_FUNCTIONS_ON,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic [31:0]             WB_DAT_O,
  output logic                    WB_ACK_O
);
  import psfs_pkg::*;

  // ****************************************************************
  // Sense synchronisers
  // ****************************************************************
  logic [SENSE_W-1:0] sense_meta;
  logic [SENSE_W-1:0] sense;
  logic               link_meta;
  logic               link_sync;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      sense_meta <= '0;
      sense      <= '0;
      link_meta  <= 1'b1;
      link_sync  <= 1'b1;
    end else if (CLK_EN) begin
      sense_meta <= SENSE;
      sense      <= sense_meta;
      link_meta  <= SERIAL_LINK_PIN_IN;
      link_sync  <= link_meta;
    end
  end

  // ****************************************************************
  // Flag logic
  // ****************************************************************
  logic [4:0] status_register_0;
  logic [2:0] status_register_1;
  logic       ce_prev;
  logic       ot_latched;
  logic       powered_up;

  wire buck_oc     = sense[SN_BUCK_OC];
  wire below_94    = sense[SN_BELOW_94];
  wire below_90    = sense[SN_BELOW_90];
  wire below_80    = sense[SN_BELOW_80];
  wire vdd_bkstop  = sense[SN_VDD_BKSTOP];
  wire supply_fail = sense[SN_VDD_5V5] | sense[SN_VDD_20V];
  wire sys_ov      = sense[SN_VDD_32V];
  wire chip_en     = sense[SN_CHIP_EN];
  wire ce_rise     = chip_en & ~ce_prev;

  wire wr_ctrl = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O &
                 (WB_ADR_I == ADDR_CTRL) & WB_SEL_I[0];
  wire cfg_ack = wr_ctrl & WB_DAT_I[CTRL_CFG_ACK];
  // Set beats clear: a brownout in the acknowledge cycle stays flagged
  wire cfg_set = ~powered_up | sense[SN_VDD_3V8];

  logic [4:0] next_status_register_0;
  logic [2:0] next_status_register_1;
  logic       next_ot;

  always_comb begin
    next_status_register_0                 = status_register_0;
    next_status_register_0[S0_BUCK_OC]     = buck_oc;
    if (below_90)
      next_status_register_0[S0_BUCK_LOW]  = 1'b1;
    else if (!below_94)
      next_status_register_0[S0_BUCK_LOW]  = 1'b0;
    // Lockout holds until chip enable is cycled
    if (below_80 || vdd_bkstop)
      next_status_register_0[S0_BUCK_LOCK] = 1'b1;
    else if (ce_rise)
      next_status_register_0[S0_BUCK_LOCK] = 1'b0;
    next_status_register_0[S0_SUPPLY_FAIL] = supply_fail;
    next_status_register_0[S0_SYS_OV]      = sys_ov;
    next_status_register_1                 = status_register_1;
    if (cfg_set)
      next_status_register_1[S1_CFG_LOST]  = 1'b1;
    else if (cfg_ack)
      next_status_register_1[S1_CFG_LOST]  = 1'b0;
    next_status_register_1[S1_TEMP_WARN]   = sense[SN_TEMP_WARN];
    next_ot = ot_latched;
    if (sense[SN_TEMP_SD])
      next_ot = 1'b1;
    else if (ce_rise && !sense[SN_TEMP_HYST])
      next_ot = 1'b0;
    next_status_register_1[S1_OVER_TEMP]   = next_ot;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      status_register_0      <= 5'h00;
      status_register_1      <= 3'h0;
      ot_latched <= 1'b0;
      ce_prev    <= 1'b0;
      powered_up <= 1'b0;
    end else if (CLK_EN) begin
      status_register_0      <= next_status_register_0;
      status_register_1      <= next_status_register_1;
      ot_latched <= next_ot;
      ce_prev    <= chip_en;
      powered_up <= 1'b1;
    end
  end

  // ****************************************************************
  // Block enables
  // ****************************************************************
  wire all_off    = sys_ov | ot_latched;
  wire buck_off   = all_off | status_register_0[S0_BUCK_LOCK]
                  | sense[SN_VDD_OVSTOP]
                  | vdd_bkstop
                  | sense[SN_VDD_4V0]
                  | sense[SN_FB_EXT];
  wire motor_off  = all_off | supply_fail | status_register_0[S0_BUCK_LOCK];

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      BUCK_ENABLE         <= 1'b0;
      BUCK_DUTY_LIMIT     <= 1'b0;
      PUMP_ENABLE         <= 1'b0;
      MOTOR_DRIVER_ENABLE <= 1'b0;
      ALL_FUNCTIONS_ON    <= 1'b0;
      LIMIT_FAULT_OUTPUT  <= 1'b1;
    end else if (CLK_EN) begin
      BUCK_ENABLE         <= ~buck_off;
      BUCK_DUTY_LIMIT     <= buck_oc & ~buck_off;
      PUMP_ENABLE         <= sense[SN_VDD_CPSTART] & ~all_off;
      MOTOR_DRIVER_ENABLE <= chip_en & ~motor_off;
      ALL_FUNCTIONS_ON    <= ~all_off;
      LIMIT_FAULT_OUTPUT  <= ~(status_register_0[S0_BUCK_LOCK] | all_off
                               | supply_fail);
    end
  end

  // ****************************************************************
  // Message queue: pending bits per message, never dropped
  // ****************************************************************
  // Rising edges of any status flag except config-lost raise a pending request
  wire rise0 = |(next_status_register_0 & ~status_register_0 & 5'h1f);
  wire rise1 = |(next_status_register_1[2:1] & ~status_register_1[2:1]);
  logic       pend0;
  logic       pend1;
  logic [1:0] tx_phase;
  logic [7:0] tx_data;
  logic       tx_start;
  logic       tx_busy;
  logic       tx_oe_n;
  wire        tx_free = ~tx_busy & ~tx_start;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      pend0    <= 1'b0;
      pend1    <= 1'b0;
      tx_phase <= 2'h0;
      tx_data  <= 8'h00;
      tx_start <= 1'b0;
    end else if (CLK_EN) begin
      tx_start <= 1'b0;
      // New event beats the clearing of the pending bit
      if (rise0)
        pend0 <= 1'b1;
      if (rise1)
        pend1 <= 1'b1;
      if (tx_free) begin
        case (tx_phase)
          2'h0: begin
            if (pend0 && !rise0) begin
              pend0    <= 1'b0;
              tx_data  <= MSG_STATUS_0;
              tx_phase <= 2'h1;
              tx_start <= 1'b1;
            end else if (pend1 && !rise1) begin
              pend1    <= 1'b0;
              tx_data  <= MSG_STATUS_1;
              tx_phase <= 2'h2;
              tx_start <= 1'b1;
            end
          end
          2'h1: begin
            tx_data  <= {3'h0, status_register_0};
            tx_phase <= 2'h0;
            tx_start <= 1'b1;
          end
          2'h2: begin
            tx_data  <= {5'h00, status_register_1};
            tx_phase <= 2'h0;
            tx_start <= 1'b1;
          end
          default: tx_phase <= 2'h0;
        endcase
      end
    end
  end

  psfs_uart_tx #(
    .BIT_CNT (BIT_CNT)
  ) u_tx (
    .clk       (CLK_SYS),
    .arst_n    (ARST_N),
    .ce        (CLK_EN),
    .start     (tx_start),
    .data      (tx_data),
    .busy      (tx_busy),
    .line_oe_n (tx_oe_n)
  );

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      SERIAL_LINK_PIN_OE_N <= 1'b1;
      SERIAL_LINK_PIN_OUT  <= 1'b0;
    end else if (CLK_EN) begin
      SERIAL_LINK_PIN_OE_N <= tx_oe_n;
      SERIAL_LINK_PIN_OUT  <= 1'b0;
    end
  end

  // ****************************************************************
  // Wishbone slave, one wait state
  // ****************************************************************
  wire        req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire [31:0] rd_mux  =
      (WB_ADR_I == ADDR_STATUS_REGISTER_0) ? {27'h0000000, status_register_0} :
      (WB_ADR_I == ADDR_STATUS_REGISTER_1) ? {29'h00000000, status_register_1} :
      (WB_ADR_I == ADDR_CTRL)  ? {31'h00000000, ~link_sync} :
      (WB_ADR_I == ADDR_SENSE) ? {15'h0000, sense} : 32'h00000000;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else if (CLK_EN) begin
      WB_ACK_O <= req;
      WB_DAT_O <= req ? rd_mux : 32'h00000000;
    end
  end
endmodule

// ---- psfs_pkg.sv ----
package psfs_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned BAUD_RATE      = 9600;
  localparam int unsigned BIT_CYCLES     = CLK_HZ / BAUD_RATE;
  localparam int unsigned CHAR_BITS      = 8;

  // ****************************************************************
  // Wishbone register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS_REGISTER_0      = 8'h00;
  localparam logic [7:0] ADDR_STATUS_REGISTER_1      = 8'h04;
  localparam logic [7:0] ADDR_CTRL       = 8'h08;
  localparam logic [7:0] ADDR_SENSE      = 8'h0c;

  // ****************************************************************
  // Status register 0 fields
  // ****************************************************************
  localparam int unsigned S0_BUCK_OC     = 0;
  localparam int unsigned S0_BUCK_LOW    = 1;
  localparam int unsigned S0_BUCK_LOCK   = 2;
  localparam int unsigned S0_SUPPLY_FAIL = 3;
  localparam int unsigned S0_SYS_OV      = 4;

  // ****************************************************************
  // Status register 1 fields
  // ****************************************************************
  localparam int unsigned S1_CFG_LOST    = 0;
  localparam int unsigned S1_TEMP_WARN   = 1;
  localparam int unsigned S1_OVER_TEMP   = 2;

  // ****************************************************************
  // Control register fields and reset value
  // ****************************************************************
  localparam int unsigned CTRL_CFG_ACK   = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;

  // ****************************************************************
  // Message header bytes on the serial link
  // ****************************************************************
  localparam logic [7:0] MSG_STATUS_0    = 8'h85;
  localparam logic [7:0] MSG_STATUS_1    = 8'h86;

  // ****************************************************************
  // Sense input bit positions
  // ****************************************************************
  localparam int unsigned SN_BUCK_OC     = 0;
  localparam int unsigned SN_BELOW_94    = 1;
  localparam int unsigned SN_BELOW_90    = 2;
  localparam int unsigned SN_BELOW_80    = 3;
  localparam int unsigned SN_VDD_OVSTOP  = 4;
  localparam int unsigned SN_VDD_BKSTOP  = 5;
  localparam int unsigned SN_VDD_4V0     = 6;
  localparam int unsigned SN_FB_EXT      = 7;
  localparam int unsigned SN_VDD_CPSTART = 8;
  localparam int unsigned SN_VDD_3V8     = 9;
  localparam int unsigned SN_VDD_5V5     = 10;
  localparam int unsigned SN_VDD_20V     = 11;
  localparam int unsigned SN_VDD_32V     = 12;
  localparam int unsigned SN_TEMP_SD     = 13;
  localparam int unsigned SN_TEMP_HYST   = 14;
  localparam int unsigned SN_TEMP_WARN   = 15;
  localparam int unsigned SN_CHIP_EN     = 16;
  localparam int unsigned SENSE_W        = 17;

  typedef enum logic [3:0] {
    PSFS_TX_IDLE  = 4'b0001,
    PSFS_TX_START = 4'b0010,
    PSFS_TX_DATA  = 4'b0100,
    PSFS_TX_STOP  = 4'b1000
  } psfs_tx_state_t;
endpackage

// ---- psfs_uart_tx.sv ----
`timescale 1ns/1ps
module psfs_uart_tx
  import psfs_pkg::*;
#(
  parameter int unsigned BIT_CNT = BIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            line_oe_n
);
  // ****************************************************************
  // 8N1 transmitter; line_oe_n low pulls the open-drain pin low
  // ****************************************************************
  psfs_tx_state_t state;
  logic [15:0]    bit_timer;
  logic [2:0]     bit_idx;
  logic [7:0]     shreg;

  wire bit_done = (bit_timer == 16'(BIT_CNT - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= PSFS_TX_IDLE;
      bit_timer <= 16'h0000;
      bit_idx   <= 3'h0;
      shreg     <= 8'h00;
      line_oe_n <= 1'b1;
      busy      <= 1'b0;
    end else if (ce) begin
      bit_timer <= (state == PSFS_TX_IDLE || bit_done) ? 16'h0000
                                                      : bit_timer + 16'h0001;
      case (state)
        PSFS_TX_IDLE: begin
          line_oe_n <= 1'b1;
          if (start) begin
            shreg     <= data;
            busy      <= 1'b1;
            line_oe_n <= 1'b0;
            state     <= PSFS_TX_START;
          end
        end
        PSFS_TX_START: begin
          if (bit_done) begin
            line_oe_n <= shreg[0];
            bit_idx   <= 3'h0;
            state     <= PSFS_TX_DATA;
          end
        end
        PSFS_TX_DATA: begin
          if (bit_done) begin
            if (bit_idx == 3'(CHAR_BITS - 1)) begin
              line_oe_n <= 1'b1;
              state     <= PSFS_TX_STOP;
            end else begin
              line_oe_n <= shreg[bit_idx + 3'h1];
              bit_idx   <= bit_idx + 3'h1;
            end
          end
        end
        PSFS_TX_STOP: begin
          if (bit_done) begin
            busy  <= 1'b0;
            state <= PSFS_TX_IDLE;
          end
        end
        default: state <= PSFS_TX_IDLE;
      endcase
    end
  end
endmodule

// ---- psfs_checker.sv ----
`timescale 1ns/1ps
module psfs_checker
  import psfs_pkg::*;
#(
  parameter int unsigned BIT_CNT = BIT_CYCLES
) (
  input wire logic               CLK_SYS,
  input wire logic               ARST_N,
  input wire logic               CLK_EN,
  input wire logic [SENSE_W-1:0] SENSE,
  input wire logic               SERIAL_LINK_PIN_OE_N,
  input wire logic               SERIAL_LINK_PIN_OUT,
  input wire logic               LIMIT_FAULT_OUTPUT,
  input wire logic               BUCK_ENABLE,
  input wire logic               BUCK_DUTY_LIMIT,
  input wire logic               PUMP_ENABLE,
  input wire logic               MOTOR_DRIVER_ENABLE,
  input wire logic               ALL_FUNCTIONS_ON,
  input wire logic               WB_CYC_I,
  input wire logic               WB_STB_I,
  input wire logic               WB_ACK_O
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // ****************************************************************
  // Levels; four samples cover the sync and output register delay, five where a latched flag adds a stage
  // ****************************************************************
  a_ovstop_buck_off:
    assert property (SENSE[SN_VDD_OVSTOP] [*4] |-> !BUCK_ENABLE)
    else $error("buck on above overvoltage stop");
  a_bkstop_buck_off:
    assert property (SENSE[SN_VDD_BKSTOP] [*4] |-> !BUCK_ENABLE)
    else $error("buck on below input stop");
  a_severe_uv_off:
    assert property (SENSE[SN_VDD_4V0] [*4] |-> !BUCK_ENABLE)
    else $error("buck on in severe undervoltage");
  a_fb_held_off:
    assert property (SENSE[SN_FB_EXT] [*4] |-> !BUCK_ENABLE)
    else $error("buck on with feedback held");
  a_pump_on_low:
    assert property (SENSE[SN_VDD_CPSTART] [*4] |-> PUMP_ENABLE)
    else $error("pump off at low supply");
  a_motor_off_uvov:
    assert property ((SENSE[SN_VDD_5V5] || SENSE[SN_VDD_20V]) [*4]
                     |-> !MOTOR_DRIVER_ENABLE)
    else $error("motor drivers on in supply fault");
  a_sys_ov_all_off:
    assert property (SENSE[SN_VDD_32V] [*4] |-> !ALL_FUNCTIONS_ON)
    else $error("functions on above system overvoltage");
  a_hot_all_off:
    assert property (SENSE[SN_TEMP_SD] [*5] |-> !ALL_FUNCTIONS_ON)
    else $error("functions on in overtemperature");
  a_oc_duty_cut:
    assert property (SENSE[SN_BUCK_OC] [*4] |-> BUCK_DUTY_LIMIT)
    else $error("duty not limited in overcurrent");
  a_lockout_pin_low:
    assert property (SENSE[SN_BELOW_80] [*5] |-> !LIMIT_FAULT_OUTPUT)
    else $error("fault output high in lockout");
  a_link_drive_low:
    assert property (!SERIAL_LINK_PIN_OUT)
    else $error("open drain pin driven high");
  // ****************************************************************
  // Link framing and bus acknowledge
  // ****************************************************************
  // A low run longer than start plus eight zero bits: stop bit lost
  logic [15:0] low_run;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      low_run <= 16'h0000;
    end else if (CLK_EN) begin
      low_run <= SERIAL_LINK_PIN_OE_N ? 16'h0000 : low_run + 16'h0001;
    end
  end

  a_link_stop_bit:
    assert property (low_run <= 16'(9 * BIT_CNT))
    else $error("serial stop bit missing");
  a_ack_one_pulse:
    assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN
                     |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus ack timing wrong");
  c_lockout: cover property (SENSE[SN_BELOW_80] && !LIMIT_FAULT_OUTPUT);
  c_hot: cover property (SENSE[SN_TEMP_SD] && !ALL_FUNCTIONS_ON);
  c_ack: cover property (WB_ACK_O);
endmodule

bind psfs_supervisor psfs_checker #(.BIT_CNT(BIT_CNT)) u_psfs_checker (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .SENSE(SENSE),
  .SERIAL_LINK_PIN_OE_N(SERIAL_LINK_PIN_OE_N),
  .SERIAL_LINK_PIN_OUT(SERIAL_LINK_PIN_OUT),
  .LIMIT_FAULT_OUTPUT(LIMIT_FAULT_OUTPUT), .BUCK_ENABLE(BUCK_ENABLE),
  .BUCK_DUTY_LIMIT(BUCK_DUTY_LIMIT), .PUMP_ENABLE(PUMP_ENABLE),
  .MOTOR_DRIVER_ENABLE(MOTOR_DRIVER_ENABLE),
  .ALL_FUNCTIONS_ON(ALL_FUNCTIONS_ON), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O));

// ---- psfs_host_model.sv ----
`timescale 1ns/1ps
module psfs_host_model #(
  parameter int unsigned BIT_CNT = 4
) (
  input  wire logic  clk,
  input  wire logic  line,
  output logic [7:0] rx_byte,
  output int         rx_cnt,
  output int         rx_bad
);
  logic [7:0] b;
  // Counters instead of a pulse so a new start bit is never missed
  initial begin
    rx_byte = 8'h00;
    rx_cnt = 0;
    rx_bad = 0;
    forever begin
      @(negedge clk);
      if (line === 1'b0) begin
        repeat (BIT_CNT / 2) @(negedge clk);
        if (line !== 1'b0) rx_bad++;
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CNT) @(negedge clk);
          b[i] = line;
        end
        repeat (BIT_CNT) @(negedge clk);
        if (line !== 1'b1) rx_bad++;
        rx_byte = b;
        rx_cnt++;
      end
    end
  end
endmodule

// ---- tb_power_supervisor_fault_status.sv ----
`timescale 1ns/1ps
module tb_power_supervisor_fault_status;
  import psfs_pkg::*;
  localparam int unsigned BC = 4;
  logic               clk, arst_n, cyc, stb, we, track;
  logic [SENSE_W-1:0] sense;
  logic [7:0]         adr;
  logic [31:0]        dat;
  wire logic          oe_n, pout, lim, buck, duty, pump, mot, allon, ack;
  wire logic [31:0]   dat_o;
  wire logic [7:0]    rx_b;
  int                 rx_cnt, rx_bad, seen, miscompares, compares, ticks;
  logic [7:0]         ser_q[$];
  logic [31:0]        rd_q[$];
  wire logic          pin;
  // Pull-up: released line reads high
  assign pin = oe_n;

  psfs_supervisor #(.BIT_CNT(BC)) u_psfs_supervisor (
    .CLK_SYS(clk), .ARST_N(arst_n), .CLK_EN(1'b1), .SENSE(sense),
    .SERIAL_LINK_PIN_IN(pin), .SERIAL_LINK_PIN_OE_N(oe_n),
    .SERIAL_LINK_PIN_OUT(pout), .LIMIT_FAULT_OUTPUT(lim),
    .BUCK_ENABLE(buck), .BUCK_DUTY_LIMIT(duty), .PUMP_ENABLE(pump),
    .MOTOR_DRIVER_ENABLE(mot), .ALL_FUNCTIONS_ON(allon),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack));
  psfs_host_model #(.BIT_CNT(BC)) u_psfs_host_model (
    .clk(clk), .line(pin), .rx_byte(rx_b), .rx_cnt(rx_cnt),
    .rx_bad(rx_bad));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic err(input string m);
    miscompares++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk(input logic a, input logic e, input string m);
    compares++;
    if (a !== e) err(m);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err("no bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic msg(input logic [7:0] h, input logic [7:0] s);
    ser_q.push_back(h);
    ser_q.push_back(s);
  endtask
  task automatic put(input int b, input logic v);
    @(posedge clk);
    sense[b] <= v;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic ce_toggle();
    put(SN_CHIP_EN, 1'b0);
    put(SN_CHIP_EN, 1'b1);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (ser_q.size() != 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (ser_q.size() != 0) err("status message missing");
    repeat (2 * BC) @(posedge clk);
  endtask

  // Result watcher: serial bytes and bus reads against the notes
  always @(posedge clk) begin
    if (rx_cnt != seen) begin
      seen = rx_cnt;
      if (track) begin
        compares++;
        if (ser_q.size() == 0) err("unexpected serial byte");
        else if (rx_b !== ser_q.pop_front()) err("serial byte wrong");
      end
    end
    if (ack === 1'b1 && we === 1'b0) begin
      compares++;
      if (rd_q.size() == 0) err("unexpected read ack");
      else if (dat_o !== rd_q.pop_front()) err("read data wrong");
    end
  end
  always @(posedge clk) begin
    ticks++;
    if (ticks > 20000) begin
      err("timeout");
      report_and_stop();
    end
  end

  initial begin
    arst_n = 1'b0;
    {cyc, stb, we, adr, dat} = '0;
    sense = '0;
    sense[SN_CHIP_EN] = 1'b1;
    track = 1'b1;
    void'($urandom(88600));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADDR_STATUS_REGISTER_1, 32'h1);
    wb(1'b1, ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS_REGISTER_1, 32'h0);
    wb(1'b1, 8'h10 + 8'($urandom_range(0, 3) * 4), $urandom());
    rd(8'h14, 32'h0);
    repeat ($urandom_range(1, 5)) @(posedge clk);
    msg(MSG_STATUS_0, 8'h01);
    put(SN_BUCK_OC, 1'b1);
    chk(duty, 1'b1, "duty limit off");
    chk(buck, 1'b1, "buck stopped by overcurrent");
    rd(ADDR_STATUS_REGISTER_0, 32'h1);
    drain();
    put(SN_BUCK_OC, 1'b0);
    rd(ADDR_STATUS_REGISTER_0, 32'h0);
    msg(MSG_STATUS_0, 8'h02);
    put(SN_BELOW_94, 1'b1);
    put(SN_BELOW_90, 1'b1);
    drain();
    put(SN_BELOW_90, 1'b0);
    rd(ADDR_STATUS_REGISTER_0, 32'h2);
    put(SN_BELOW_94, 1'b0);
    rd(ADDR_STATUS_REGISTER_0, 32'h0);
    msg(MSG_STATUS_0, 8'h08);
    put(SN_VDD_5V5, 1'b1);
    chk(mot, 1'b0, "motor on in undervoltage");
    chk(allon, 1'b1, "functions off in undervoltage");
    rd(ADDR_STATUS_REGISTER_0, 32'h8);
    drain();
    put(SN_VDD_5V5, 1'b0);
    msg(MSG_STATUS_0, 8'h04);
    msg(MSG_STATUS_1, 8'h02);
    @(posedge clk);
    sense[SN_BELOW_80] <= 1'b1;
    sense[SN_TEMP_WARN] <= 1'b1;
    put(SN_CHIP_EN, 1'b1);
    chk(lim, 1'b0, "fault output high");
    chk(buck, 1'b0, "buck on in lockout");
    drain();
    put(SN_TEMP_WARN, 1'b0);
    put(SN_BELOW_80, 1'b0);
    ce_toggle();
    chk(buck, 1'b1, "buck not back");
    msg(MSG_STATUS_0, 8'h04);
    put(SN_VDD_BKSTOP, 1'b1);
    chk(buck, 1'b0, "buck on below input stop");
    drain();
    put(SN_VDD_BKSTOP, 1'b0);
    ce_toggle();
    chk(lim, 1'b1, "fault output stuck");
    msg(MSG_STATUS_1, 8'h04);
    @(posedge clk);
    sense[SN_TEMP_HYST] <= 1'b1;
    put(SN_TEMP_SD, 1'b1);
    chk(allon, 1'b0, "functions on when hot");
    drain();
    put(SN_TEMP_SD, 1'b0);
    ce_toggle();
    chk(allon, 1'b0, "resumed above hysteresis");
    put(SN_TEMP_HYST, 1'b0);
    chk(allon, 1'b0, "resumed without enable toggle");
    ce_toggle();
    chk(allon, 1'b1, "no resume after toggle");
    // Sweep the remaining stop levels; their messages are not scored
    track = 1'b0;
    put(SN_VDD_OVSTOP, 1'b1);
    chk(buck, 1'b0, "buck on above stop level");
    put(SN_VDD_OVSTOP, 1'b0);
    put(SN_VDD_4V0, 1'b1);
    chk(buck, 1'b0, "buck on in severe undervoltage");
    put(SN_VDD_4V0, 1'b0);
    put(SN_FB_EXT, 1'b1);
    chk(buck, 1'b0, "buck on with feedback held");
    put(SN_FB_EXT, 1'b0);
    put(SN_VDD_CPSTART, 1'b1);
    chk(pump, 1'b1, "pump off at low supply");
    put(SN_VDD_CPSTART, 1'b0);
    put(SN_VDD_20V, 1'b1);
    chk(mot, 1'b0, "motor on in overvoltage");
    put(SN_VDD_20V, 1'b0);
    put(SN_VDD_32V, 1'b1);
    chk(allon, 1'b0, "functions on above 32V");
    put(SN_VDD_32V, 1'b0);
    repeat (1500) @(posedge clk);
    ce_toggle();
    track = 1'b1;
    compares++;
    if (rx_bad != 0) err("serial framing wrong");
    report_and_stop();
  end
endmodule
